// ===== rtl/ddr2_mode_ctrl.sv
// device side command decode, mode registers, dll and init tracking
// ==========================================================================
// Summary of operation
// - only nop or deselect during register write
// - burst length four or eight only
// - activate gives row, access gives column
// - register writes leave array intact
// - all low with bank zero writes mode
// - mode register field layout
// - bank one selects extended register one
// - extended register one field layout
// - dll off in self refresh, on after
`timescale 1ns/1ps
module ddr2_mode_ctrl
    import ddr2_mode_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // command pins, sampled on rising edges
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [1:0] ba_i,
    input wire logic [ADDR_W-1:0] addr_i,
    // decoded register contents
    output logic [2:0] burst_len_o,
    output logic burst_type_o,
    output logic [2:0] cas_lat_o,
    output logic [2:0] wr_recovery_o,
    output logic [2:0] add_lat_o,
    output logic [2:0] cal_mode_o,
    output logic half_drive_o,
    output logic [1:0] term_sel_o,
    output logic strobe_n_dis_o,
    output logic read_strobe_en_o,
    // row and column capture
    output logic [1:0] bank_o,
    output logic [ADDR_W-1:0] row_o,
    output logic [ADDR_W-1:0] col_o,
    output logic auto_pre_o,
    // status
    output logic dll_on_o,
    output logic dll_locked_o,
    output logic init_done_o,
    output logic reg_busy_o,
    output logic illegal_o
);
    // ======================================================================
    // command decode
    logic [3:0] cmd;
    logic is_mrs, is_act, is_rd, is_wr, is_pre, is_ref, is_nop;
    logic self_entry;
    assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
    assign is_nop = cs_n_i || (cmd == CMD_NOP);
    assign is_mrs = !cs_n_i && (cmd == CMD_MRS);
    assign is_act = !cs_n_i && (cmd == CMD_ACT);
    assign is_rd = !cs_n_i && (cmd == CMD_READ);
    assign is_wr = !cs_n_i && (cmd == CMD_WRITE);
    assign is_pre = !cs_n_i && (cmd == CMD_PRE);
    assign is_ref = !cs_n_i && (cmd == CMD_REF) && cke_i;
    assign self_entry = !cs_n_i && (cmd == CMD_REF) && !cke_i;

    dev_state_t state_q;
    logic [ADDR_W-1:0] mr_q, em1_q;
    logic [1:0] ref_cnt_q;
    logic dll_rst_seen_q, cal_default_q;
    logic mrd_busy, lock_busy;
    logic mrd_load, lock_load;
    logic wr_mode, wr_ext1;

    assign wr_mode = is_mrs && (ba_i == SEL_MODE) && (state_q == ST_IDLE);
    assign wr_ext1 = is_mrs && (ba_i == SEL_EXT1) && (state_q == ST_IDLE);
    assign mrd_load = is_mrs && (state_q == ST_IDLE);
    // dll lock restarts on a reset request or on leaving self refresh
    assign lock_load = (wr_mode && addr_i[MR_DLLRST_BIT])
        || (state_q == ST_SELF_REF && cke_i);

    // ======================================================================
    // timers
    mode_wait_timer #(.W(CNT_W)) u_mrd (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(mrd_load),
        .count_i(MRD_CNT),
        .busy_o(mrd_busy)
    );
    mode_wait_timer #(.W(CNT_W)) u_lock (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(lock_load),
        .count_i(DLL_LOCK_CNT),
        .busy_o(lock_busy)
    );

    // ======================================================================
    // state tracking; register access returns to idle after the wait
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_POWERUP;
        end else begin
            case (state_q)
                ST_POWERUP: begin
                    if (cke_i) state_q <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (wr_mode) state_q <= ST_MODE_ACC;
                    else if (is_mrs) state_q <= ST_EXT_ACC;
                    else if (self_entry) state_q <= ST_SELF_REF;
                    else if (is_act) state_q <= ST_ACTIVE;
                end
                ST_MODE_ACC, ST_EXT_ACC: begin
                    if (!mrd_busy) state_q <= ST_IDLE;
                end
                ST_SELF_REF: begin
                    if (cke_i) state_q <= ST_IDLE;
                end
                ST_ACTIVE: begin
                    if (is_pre && addr_i[AP_BIT]) state_q <= ST_IDLE;
                end
                default: state_q <= ST_POWERUP;
            endcase
        end
    end

    // any non-nop during a register write wait is flagged
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            illegal_o <= 1'b0;
        end else begin
            illegal_o <= ((state_q == ST_MODE_ACC || state_q == ST_EXT_ACC) && !is_nop)
                || (is_rd && lock_busy);
        end
    end

    // ======================================================================
    // register storage; whole word replaced each write, array untouched
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mr_q <= MR_RESET;
        end else if (wr_mode) begin
            mr_q <= addr_i;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            em1_q <= EM_RESET;
        end else if (wr_ext1) begin
            em1_q <= addr_i;
        end
    end

    // calibration default must be followed by exit before normal use
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cal_default_q <= 1'b0;
        end else if (wr_ext1) begin
            cal_default_q <= (addr_i[EM_CAL_LSB +: 3] == CAL_DEFAULT);
        end
    end

    // init progress: dll reset seen, then refreshes, then final mode write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dll_rst_seen_q <= 1'b0;
            ref_cnt_q <= '0;
            init_done_o <= 1'b0;
        end else if (wr_mode && addr_i[MR_DLLRST_BIT]) begin
            dll_rst_seen_q <= 1'b1;
            ref_cnt_q <= '0;
        end else if (is_ref && dll_rst_seen_q && ref_cnt_q != 2'h3) begin
            ref_cnt_q <= ref_cnt_q + 2'h1;
        end else if (wr_mode && ref_cnt_q >= 2'(MIN_REFRESH_CMDS)) begin
            init_done_o <= 1'b1;
        end
    end

    // ======================================================================
    // row and column capture
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bank_o <= '0;
            row_o <= '0;
        end else if (is_act && state_q == ST_IDLE) begin
            bank_o <= ba_i;
            row_o <= addr_i;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            col_o <= '0;
            auto_pre_o <= 1'b0;
        end else if ((is_rd || is_wr) && state_q == ST_ACTIVE) begin
            col_o <= addr_i;
            auto_pre_o <= addr_i[AP_BIT];
        end
    end

    // ======================================================================
    // decoded fields; burst codes other than eight fall back to four
    always_comb begin
        burst_len_o = (mr_q[MR_BL_LSB +: 3] == BL_EIGHT) ? BL_EIGHT : BL_FOUR;
    end
    assign burst_type_o = mr_q[MR_BT_BIT];
    assign cas_lat_o = mr_q[MR_CL_LSB +: 3];
    assign wr_recovery_o = mr_q[MR_WR_LSB +: 3];
    assign add_lat_o = em1_q[EM_AL_LSB +: 3];
    assign cal_mode_o = em1_q[EM_CAL_LSB +: 3];
    assign half_drive_o = em1_q[EM_HALFDRV_BIT];
    assign term_sel_o = {em1_q[EM_RTT1_BIT], em1_q[EM_RTT0_BIT]};
    assign strobe_n_dis_o = em1_q[EM_DQSDIS_BIT];
    assign read_strobe_en_o = em1_q[EM_READ_STROBE_OUTPUT_BIT];
    assign dll_on_o = !em1_q[EM_DLLDIS_BIT] && (state_q != ST_SELF_REF);
    assign dll_locked_o = dll_on_o && dll_rst_seen_q && !lock_busy;
    assign reg_busy_o = (state_q == ST_MODE_ACC) || (state_q == ST_EXT_ACC);

    // ======================================================================
    // checks
    chk_busy_nop: assert property (@(posedge clk_i) disable iff (rst_i)
        (reg_busy_o && !is_nop) |=> illegal_o)
        else $error("non-nop during register write not flagged");
    chk_mode_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == ST_IDLE && wr_mode) |=> reg_busy_o ##1 reg_busy_o)
        else $error("mode write wait too short");
    chk_mode_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_mode |=> (mr_q == $past(addr_i)))
        else $error("mode register not written");
    chk_ext_store: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ext1 |=> (add_lat_o == $past(addr_i[EM_AL_LSB +: 3])))
        else $error("extended register one not written");
    chk_burst_len: assert property (@(posedge clk_i) disable iff (rst_i)
        (burst_len_o == BL_FOUR) || (burst_len_o == BL_EIGHT))
        else $error("bad burst length");
    chk_burst_eight: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_mode && addr_i[MR_BL_LSB +: 3] == BL_EIGHT) |=> (burst_len_o == BL_EIGHT))
        else $error("burst length eight not taken");
    chk_row_cap: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_act && state_q == ST_IDLE) |=> (row_o == $past(addr_i)))
        else $error("row not captured");
    chk_self_dll: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == ST_SELF_REF) |-> !dll_on_o)
        else $error("dll on in self refresh");
    chk_lock_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_mode && addr_i[MR_DLLRST_BIT]) |=> !dll_locked_o [*8])
        else $error("dll lock reported early");
    chk_init_order: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(init_done_o) |-> dll_rst_seen_q)
        else $error("init done without dll reset");
    cov_mode_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_mode);
    cov_self_ref: cover property (@(posedge clk_i) disable iff (rst_i)
        state_q == ST_SELF_REF);
    cov_init_done: cover property (@(posedge clk_i) disable iff (rst_i) $rose(init_done_o));
    // calibration default left again by an extended register one write with any other calibration code
    cov_cal_exit: cover property (@(posedge clk_i) disable iff (rst_i) $fell(cal_default_q));
endmodule : ddr2_mode_ctrl

// ===== rtl/ddr2_mode_pkg.sv
// package: command encodings, register fields, timing counts for the mode block
package ddr2_mode_pkg;
    // ======================================================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int MODE_SET_CYCLE_TIME_CK = 2; // mode_set_cycle_time in clocks
    localparam int DLL_LOCK_CK = 200; // clocks from dll reset until reads
    localparam int CNT_W = 8;
    // counter loads derived from the clock counts so each count lives in one place
    localparam logic [CNT_W-1:0] DLL_LOCK_CNT = CNT_W'(DLL_LOCK_CK);
    localparam logic [CNT_W-1:0] MRD_CNT = CNT_W'(MODE_SET_CYCLE_TIME_CK);
    localparam int MIN_REFRESH_CMDS = 2;

    // ======================================================================
    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;

    // ======================================================================
    // bank selects for register writes
    localparam logic [1:0] SEL_MODE = 2'h0;
    localparam logic [1:0] SEL_EXT1 = 2'h1;
    localparam logic [1:0] SEL_EXT2 = 2'h2;
    localparam logic [1:0] SEL_EXT3 = 2'h3;

    // ======================================================================
    // field positions
    localparam int ADDR_W = 13;
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_TM_BIT = 7;
    localparam int MR_DLLRST_BIT = 8;
    localparam int MR_WR_LSB = 9;
    localparam int EM_DLLDIS_BIT = 0;
    localparam int EM_HALFDRV_BIT = 1;
    localparam int EM_RTT0_BIT = 2;
    localparam int EM_AL_LSB = 3;
    localparam int EM_RTT1_BIT = 6;
    localparam int EM_CAL_LSB = 7;
    localparam int EM_DQSDIS_BIT = 10;
    localparam int EM_READ_STROBE_OUTPUT_BIT = 11;
    localparam int AP_BIT = 10;

    // ======================================================================
    // field values and reset contents
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;
    localparam logic [2:0] CAL_EXIT = 3'h0;
    localparam logic [2:0] CAL_DEFAULT = 3'h7;
    localparam logic [12:0] MR_RESET = 13'h0000;
    localparam logic [12:0] EM_RESET = 13'h0000;

    // device states
    typedef enum logic [2:0] {
        ST_POWERUP = 3'b000,
        ST_IDLE = 3'b001,
        ST_MODE_ACC = 3'b010,
        ST_EXT_ACC = 3'b011,
        ST_SELF_REF = 3'b100,
        ST_ACTIVE = 3'b101
    } dev_state_t;
endpackage : ddr2_mode_pkg

// ===== rtl/mode_wait_timer.sv
// down counter used for mode set wait and dll lock wait
`timescale 1ns/1ps
module mode_wait_timer
    import ddr2_mode_pkg::*;
#(
    parameter int W = CNT_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    // status
    output logic busy_o
);
    logic [W-1:0] cnt_q;

    // load wins over counting so a restart is never lost
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= count_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign busy_o = (cnt_q != '0);
endmodule : mode_wait_timer

// ===== testbench/ddr2_ctrl_model.sv
// controller-side model that drives the command pins of the mode block
`timescale 1ns/1ps
module ddr2_ctrl_model
    import ddr2_mode_pkg::*;
(
    // clock
    input wire logic clk_i,
    // command pins toward the device
    output logic cke_o,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [1:0] ba_o,
    output logic [ADDR_W-1:0] addr_o
);
    // ======================================================================
    // pins at time zero: clock enable low through power-up
    initial begin
        cke_o = 1'b0;
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = CMD_NOP;
        ba_o = 2'h0;
        addr_o = 13'h0000;
    end

    // one command on a falling edge, then gap deselect cycles
    task automatic issue(input logic [3:0] code, input logic [1:0] ba,
                         input logic [ADDR_W-1:0] addr, input logic cke, input int gap);
        @(negedge clk_i);
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = code;
        cke_o = cke;
        ba_o = ba;
        addr_o = addr;
        repeat (gap) begin
            @(negedge clk_i);
            cs_n_o = 1'b1; // deselect; bus released, so it shows the inverse
            ba_o = ~ba_o;
            addr_o = ~addr_o;
        end
    endtask : issue

    // ======================================================================
    // full power-up order; four deselects cover the mode set cycle time
    task automatic power_up(input int stable_ck, input logic [ADDR_W-1:0] mr_word);
        repeat (stable_ck) @(negedge clk_i);
        issue(CMD_NOP, 2'h0, 13'h0000, 1'b1, 4);
        issue(CMD_PRE, 2'h0, 13'h0400, 1'b1, 2);
        issue(CMD_MRS, SEL_EXT2, 13'h0000, 1'b1, 4);
        issue(CMD_MRS, SEL_EXT3, 13'h0000, 1'b1, 4);
        issue(CMD_MRS, SEL_EXT1, 13'h0000, 1'b1, 4);
        issue(CMD_MRS, SEL_MODE, 13'h0100, 1'b1, 4);
        issue(CMD_PRE, 2'h0, 13'h0400, 1'b1, 2);
        repeat (2) issue(CMD_REF, 2'h0, 13'h0000, 1'b1, 4);
        issue(CMD_MRS, SEL_MODE, mr_word, 1'b1, 4);
        repeat (200) @(negedge clk_i);
        issue(CMD_MRS, SEL_EXT1, 13'h0380, 1'b1, 4);
        issue(CMD_MRS, SEL_EXT1, 13'h0000, 1'b1, 4);
    endtask : power_up
endmodule : ddr2_ctrl_model

// ===== testbench/ddr2_mode_ctrl_bench.sv
// self-checking bench for the mode register and init tracking block
`timescale 1ns/1ps
module ddr2_mode_ctrl_bench
    import ddr2_mode_pkg::*;
();
    `define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
        $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

    // ======================================================================
    // signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0] ba, bank, term;
    logic [ADDR_W-1:0] addr, row, col;
    logic [2:0] bl, cl, wr, al, cal;
    logic bt, half, sdis, rsen, apre, dll_on, locked, done, busy, ill;
    int num_errors = 0;
    int compares = 0;
    int ill_cnt = 0;
    int n, base;

    // register writes and the fields they should show
    typedef struct packed {
        logic [1:0] ba;
        logic [12:0] addr;
        logic [11:0] exp;
    } row_t;
    row_t rows [8] = '{'{SEL_MODE, 13'h065B, 12'h1EB}, '{SEL_MODE, 13'h0432, 12'h11A},
        '{SEL_MODE, 13'h0001, 12'h100}, '{SEL_EXT2, 13'h0000, 12'h100},
        '{SEL_EXT1, 13'h0C26, 12'h82F}, '{SEL_EXT1, 13'h03D8, 12'h7D1},
        '{SEL_EXT1, 13'h0001, 12'h000}, '{SEL_EXT1, 13'h0000, 12'h001}};
    logic [3:0] bad [6] = '{CMD_READ, CMD_WRITE, CMD_ACT, CMD_PRE, CMD_REF, CMD_MRS};

    // ======================================================================
    // clock, illegal pulse counter, instances
    always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

    always @(posedge clk_i) if (ill === 1'b1) ill_cnt <= ill_cnt + 1;

    ddr2_mode_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cke_i(cke), .cs_n_i(cs_n),
        .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr),
        .burst_len_o(bl), .burst_type_o(bt), .cas_lat_o(cl), .wr_recovery_o(wr),
        .add_lat_o(al), .cal_mode_o(cal), .half_drive_o(half), .term_sel_o(term),
        .strobe_n_dis_o(sdis), .read_strobe_en_o(rsen), .bank_o(bank), .row_o(row),
        .col_o(col), .auto_pre_o(apre), .dll_on_o(dll_on), .dll_locked_o(locked),
        .init_done_o(done), .reg_busy_o(busy), .illegal_o(ill));

    ddr2_ctrl_model u_ctrl (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
        .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr));

    // ======================================================================
    // helpers
    function automatic logic [11:0] seen(input logic [1:0] sel);
        if (sel == SEL_EXT1) return {al, cal, half, term, sdis, rsen, dll_on};
        return {2'h0, bl, bt, cl, wr};
    endfunction : seen

    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // bounded wait on the busy flag; running out ends the run
    task automatic wait_busy(input logic lvl, input int lim);
        for (n = 0; n < lim && busy !== lvl; n++) @(negedge clk_i);
        `CHK("reg_busy", lvl, busy)
        if (busy !== lvl) end_of_test();
    endtask : wait_busy

    // ======================================================================
    // main sequence
    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        `CHK("reset outputs", 7'h28, {bl, dll_on, done, busy, ill})
        $display("test reset done");
        // write_recovery_time of 15 ns rounds up to one clock at this rate
        u_ctrl.power_up(200_000 / CLK_PERIOD_NS, 13'h0242);
        `CHK("init_done", 1'b1, done)
        `CHK("dll_locked", 1'b1, locked)
        `CHK("cal_mode", 3'h0, cal)
        `CHK("init illegal", 0, ill_cnt)
        $display("test power-up done");
        foreach (rows[k]) begin
            u_ctrl.issue(CMD_MRS, rows[k].ba, rows[k].addr, 1'b1, 5);
            `CHK("fields", rows[k].exp, seen(rows[k].ba))
        end
        $display("test register rows done");
        u_ctrl.issue(CMD_MRS, SEL_MODE, 13'h0242, 1'b1, 1);
        wait_busy(1'b1, 3);
        wait_busy(1'b0, 6);
        // every non-nop right behind a register write is refused
        foreach (bad[k]) begin
            base = ill_cnt;
            u_ctrl.issue(CMD_MRS, SEL_MODE, 13'h0242, 1'b1, 0);
            u_ctrl.issue(bad[k], SEL_EXT1, 13'h1FFF, 1'b1, 5);
            `CHK("flagged", base + 1, ill_cnt)
            `CHK("mode kept", 12'h121, seen(SEL_MODE))
            `CHK("ext kept", 12'h001, seen(SEL_EXT1))
        end
        $display("test busy refusals done");
        u_ctrl.issue(CMD_MRS, SEL_MODE, 13'h0342, 1'b1, 4);
        `CHK("relock", 1'b0, locked)
        base = ill_cnt;
        u_ctrl.issue(CMD_ACT, 2'h2, 13'h1ABC, 1'b1, 1);
        u_ctrl.issue(CMD_READ, 2'h2, 13'h0407, 1'b1, 2);
        `CHK("early read", base + 1, ill_cnt)
        `CHK("bank row", {2'h2, 13'h1ABC}, {bank, row})
        for (n = 0; n < 260 && locked !== 1'b1; n++) @(negedge clk_i);
        `CHK("lock time", 1'b1, locked === 1'b1 && n >= 180)
        if (locked !== 1'b1) end_of_test();
        u_ctrl.issue(CMD_READ, 2'h2, 13'h0407, 1'b1, 2);
        `CHK("late read", base + 1, ill_cnt)
        `CHK("column", {1'b1, 10'h007}, {apre, col[9:0]})
        u_ctrl.issue(CMD_WRITE, 2'h2, 13'h0015, 1'b1, 2);
        `CHK("write column", {1'b0, 10'h015}, {apre, col[9:0]})
        `CHK("write legal", base + 1, ill_cnt)
        u_ctrl.issue(CMD_PRE, 2'h0, 13'h0400, 1'b1, 2);
        $display("test lock and access done");
        u_ctrl.issue(CMD_REF, 2'h0, 13'h0000, 1'b0, 3);
        `CHK("dll in self refresh", 1'b0, dll_on)
        u_ctrl.issue(CMD_NOP, 2'h0, 13'h0000, 1'b1, 3);
        `CHK("dll after exit", 2'b10, {dll_on, locked})
        $display("test self refresh done");
        end_of_test();
    end
endmodule : ddr2_mode_ctrl_bench
